/* cctc_top.sv */
`timescale 1ns/1ps
// charger timer and current configuration bank
module cctc_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        reg_wr,                 // write strobe, one cycle
    input  wire logic        reg_rd,                 // read strobe, one cycle
    input  wire logic [7:0]  reg_addr,               // register offset
    input  wire logic [7:0]  reg_wdata,              // write data
    input  wire logic        charge_enable_n,        // 0 while charging
    input  wire logic        low_current_range_select,
    output logic      [7:0]  reg_rdata_ff,           // read data, held
    output logic             timer_half_rate_enable_ff,
    output logic             timer_disabled_ff,
    output logic      [10:0] timer_period_min_ff,    // effective minutes
    output logic      [15:0] charge_current_dma_ff,  // 0.1 mA units
    output logic             charge_code_reserved_ff,
    output logic      [15:0] preterm_current_dma_ff, // 0.1 mA units
    output logic             preterm_code_reserved_ff
);
    logic [7:0]  tmr_q;     // timer control byte
    logic [7:0]  chg_q;     // charge current byte
    logic [7:0]  pre_q;     // precharge/termination byte
    logic        tmr_we;    // decoded write enables
    logic        chg_we;
    logic        pre_we;
    logic        tmr_lock;  // timer byte frozen while charging
    logic [7:0]  nxt_rdata;
    logic        nxt_half;
    logic        nxt_off;
    logic [10:0] nxt_min;
    logic [15:0] nxt_chg;
    logic        nxt_chg_res;
    logic [15:0] nxt_pre;
    logic        nxt_pre_res;

    // address decode
    assign tmr_we   = reg_wr && (reg_addr == cctc_pkg::CCTC_TIMER_CTRL_OFS);
    assign chg_we   = reg_wr && (reg_addr == cctc_pkg::CCTC_CHG_CODE_OFS);
    assign pre_we   = reg_wr && (reg_addr == cctc_pkg::CCTC_PRETERM_OFS);
    assign tmr_lock = !charge_enable_n;

    // timer byte; locked while charge_enable_n is low
    cctc_reg8 #(.RST(cctc_pkg::CCTC_TIMER_CTRL_RST), .MSK(cctc_pkg::CCTC_TIMER_CTRL_MSK))
    u_tmr (.clk(clk), .nrst(nrst), .we(tmr_we), .lock(tmr_lock), .wdata(reg_wdata),
           .q_ff(tmr_q));
    // current codes are never locked
    cctc_reg8 #(.RST(cctc_pkg::CCTC_CHG_CODE_RST), .MSK(cctc_pkg::CCTC_CODE_MSK))
    u_chg (.clk(clk), .nrst(nrst), .we(chg_we), .lock(1'b0), .wdata(reg_wdata),
           .q_ff(chg_q));
    cctc_reg8 #(.RST(cctc_pkg::CCTC_PRETERM_RST), .MSK(cctc_pkg::CCTC_CODE_MSK))
    u_pre (.clk(clk), .nrst(nrst), .we(pre_we), .lock(1'b0), .wdata(reg_wdata),
           .q_ff(pre_q));

    // read mux; unmapped offsets read zero, data held between reads
    always_comb begin
        nxt_rdata = reg_rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                cctc_pkg::CCTC_TIMER_CTRL_OFS: nxt_rdata = tmr_q;
                cctc_pkg::CCTC_CHG_CODE_OFS:   nxt_rdata = chg_q;
                cctc_pkg::CCTC_PRETERM_OFS:    nxt_rdata = pre_q;
                default:                       nxt_rdata = 8'h00;
            endcase
        end
    end

    // timer decode; half rate doubles the wall-clock period
    always_comb begin
        nxt_half = tmr_q[cctc_pkg::CCTC_HALF_RATE_BIT];
        nxt_off  = 1'b0;
        nxt_min  = 11'h000;
        unique case (tmr_q[cctc_pkg::CCTC_PERIOD_LSB +: 2])
            cctc_pkg::CCTC_PER_30M: nxt_min = cctc_pkg::CCTC_MIN_30M;
            cctc_pkg::CCTC_PER_3H:  nxt_min = cctc_pkg::CCTC_MIN_3H;
            cctc_pkg::CCTC_PER_9H:  nxt_min = cctc_pkg::CCTC_MIN_9H;
            cctc_pkg::CCTC_PER_OFF: nxt_off = 1'b1;
        endcase
        if (nxt_half) begin
            nxt_min = nxt_min << 1;
        end
    end

    // charge current decode; reserved codes give zero current
    always_comb begin
        nxt_chg     = 16'h0000;
        nxt_chg_res = 1'b0;
        if (low_current_range_select && chg_q[6:0] <= cctc_pkg::CCTC_LOW_LAST) begin
            nxt_chg = cctc_pkg::CCTC_LOW_BASE
                    + 16'(chg_q[6:0]) * cctc_pkg::CCTC_LOW_STEP;
        end else if (chg_q[6:0] < cctc_pkg::CCTC_CHG_STEP10) begin
            nxt_chg = cctc_pkg::CCTC_CHG_BASE
                    + 16'(chg_q[6:0]) * cctc_pkg::CCTC_STEP_1MA;
        end else if (chg_q[6:0] <= cctc_pkg::CCTC_CHG_LAST) begin
            nxt_chg = cctc_pkg::CCTC_CHG_240
                    + 16'(chg_q[6:0] - cctc_pkg::CCTC_CHG_STEP10)
                    * cctc_pkg::CCTC_STEP_10MA;
        end else begin
            nxt_chg_res = 1'b1;
        end
    end

    // precharge/termination decode; the gap and the codes above 50 mA are reserved
    always_comb begin
        nxt_pre     = 16'h0000;
        nxt_pre_res = 1'b0;
        if (pre_q[6:0] <= cctc_pkg::CCTC_PRE_FINE_END) begin
            nxt_pre = 16'(pre_q[6:0] + 7'h01) * cctc_pkg::CCTC_PRE_STEP;
        end else if (pre_q[6:0] >= cctc_pkg::CCTC_PRE_COARSE
                     && pre_q[6:0] <= cctc_pkg::CCTC_PRE_LAST) begin
            nxt_pre = cctc_pkg::CCTC_PRE_6MA
                    + 16'(pre_q[6:0] - cctc_pkg::CCTC_PRE_COARSE)
                    * cctc_pkg::CCTC_STEP_1MA;
        end else begin
            nxt_pre_res = 1'b1;
        end
    end

    // output registers; decode lags the stored byte by one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff              <= 8'h00;
            timer_half_rate_enable_ff <= 1'b1;
            timer_disabled_ff         <= 1'b0;
            timer_period_min_ff       <= 11'h000;
            charge_current_dma_ff     <= 16'h0000;
            charge_code_reserved_ff   <= 1'b0;
            preterm_current_dma_ff    <= 16'h0000;
            preterm_code_reserved_ff  <= 1'b0;
        end else begin
            reg_rdata_ff              <= nxt_rdata;
            timer_half_rate_enable_ff <= nxt_half;
            timer_disabled_ff         <= nxt_off;
            timer_period_min_ff       <= nxt_min;
            charge_current_dma_ff     <= nxt_chg;
            charge_code_reserved_ff   <= nxt_chg_res;
            preterm_current_dma_ff    <= nxt_pre;
            preterm_code_reserved_ff  <= nxt_pre_res;
        end
    end

    // an unlocked write of bit 3 shows on the output two edges later
    property p_half_rate;
        @(posedge clk) disable iff (!nrst)
        (tmr_we && charge_enable_n) |-> ##2 (timer_half_rate_enable_ff == $past(reg_wdata[3], 2));
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate bit not taken");

    // a locked write leaves the timer byte unchanged
    property p_lock;
        @(posedge clk) disable iff (!nrst)
        (tmr_we && !charge_enable_n) |=> $stable(tmr_q);
    endproperty
    a_lock: assert property (p_lock) else $error("timer byte written while locked");

    // 9 h period code maps to 540 minutes at full rate
    property p_period;
        @(posedge clk) disable iff (!nrst)
        (tmr_q[1:0] == 2'h2 && !tmr_q[3]) |=> (timer_period_min_ff == 11'h21c);
    endproperty
    a_period: assert property (p_period) else $error("9 h period wrong");

    // shortest period at full rate
    property p_period_short;
        @(posedge clk) disable iff (!nrst)
        (tmr_q[1:0] == 2'h0 && !tmr_q[3]) |=> (timer_period_min_ff == 11'h01e);
    endproperty
    a_period_short: assert property (p_period_short) else $error("30 m period wrong");

    // half rate stretches the 9 h period to 18 h of wall-clock time
    property p_half_double;
        @(posedge clk) disable iff (!nrst)
        (tmr_q[1:0] == 2'h2 && tmr_q[3]) |=> (timer_period_min_ff == 11'h438);
    endproperty
    a_half_double: assert property (p_half_double) else $error("half rate period wrong");

    property p_off;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (timer_disabled_ff == ($past(tmr_q[1:0]) == 2'h3));
    endproperty
    a_off: assert property (p_off) else $error("timer disable decode wrong");

    // low range code 7 gives 4.8 mA
    property p_low;
        @(posedge clk) disable iff (!nrst)
        (low_current_range_select && chg_q[6:0] == 7'h07) |=> (charge_current_dma_ff == 16'h0030);
    endproperty
    a_low: assert property (p_low) else $error("low range decode wrong");

    // low range code 0 gives 2.0 mA, not the normal 5 mA
    property p_low_base;
        @(posedge clk) disable iff (!nrst)
        (low_current_range_select && chg_q[6:0] == 7'h00) |=>
            (charge_current_dma_ff == 16'h0014);
    endproperty
    a_low_base: assert property (p_low_base) else $error("low range base wrong");

    // preterm code 4 gives 2.5 mA
    property p_pre;
        @(posedge clk) disable iff (!nrst)
        (pre_q[6:0] == 7'h04) |=> (preterm_current_dma_ff == 16'h0019);
    endproperty
    a_pre: assert property (p_pre) else $error("preterm decode wrong");

    // last coarse preterm code gives 50 mA
    property p_pre_top;
        @(posedge clk) disable iff (!nrst)
        (pre_q[6:0] == 7'h6c) |=>
            (preterm_current_dma_ff == 16'h01f4 && !preterm_code_reserved_ff);
    endproperty
    a_pre_top: assert property (p_pre_top) else $error("preterm top code wrong");

    property p_pre_res;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (preterm_code_reserved_ff ==
                  (($past(pre_q[6:0]) > 7'h09 && $past(pre_q[6:0]) < 7'h40)
                   || $past(pre_q[6:0]) > 7'h6c));
    endproperty
    a_pre_res: assert property (p_pre_res) else $error("preterm reserved flag wrong");

    // charge code 0x6e gives 500 mA; above is reserved
    property p_chg;
        @(posedge clk) disable iff (!nrst)
        (!low_current_range_select && chg_q[6:0] == 7'h6e) |=>
            (charge_current_dma_ff == 16'h1388 && !charge_code_reserved_ff);
    endproperty
    a_chg: assert property (p_chg) else $error("charge decode wrong");

    // codes above 0x6e are reserved in either range and drive no current
    property p_chg_res;
        @(posedge clk) disable iff (!nrst)
        (chg_q[6:0] > 7'h6e) |=>
            (charge_code_reserved_ff && charge_current_dma_ff == 16'h0000);
    endproperty
    a_chg_res: assert property (p_chg_res) else $error("charge reserved decode wrong");
endmodule // cctc_top

/* cctc_pkg.sv */
package cctc_pkg;
    // register offsets on the register port
    localparam logic [7:0] CCTC_TIMER_CTRL_OFS = 8'h21;
    localparam logic [7:0] CCTC_CHG_CODE_OFS   = 8'h22;
    localparam logic [7:0] CCTC_PRETERM_OFS    = 8'h23;
    // reset values
    localparam logic [7:0] CCTC_TIMER_CTRL_RST = 8'h19;
    localparam logic [7:0] CCTC_CHG_CODE_RST   = 8'h41;
    localparam logic [7:0] CCTC_PRETERM_RST    = 8'h04;
    // writable bits; reserved bits read as zero
    localparam logic [7:0] CCTC_TIMER_CTRL_MSK = 8'h7b;
    localparam logic [7:0] CCTC_CODE_MSK       = 8'h7f;
    // field positions
    localparam int CCTC_HALF_RATE_BIT = 3;
    localparam int CCTC_PERIOD_LSB    = 0;
    // period codes
    localparam logic [1:0] CCTC_PER_30M = 2'h0;
    localparam logic [1:0] CCTC_PER_3H  = 2'h1;
    localparam logic [1:0] CCTC_PER_9H  = 2'h2;
    localparam logic [1:0] CCTC_PER_OFF = 2'h3;
    // period lengths in minutes
    localparam logic [10:0] CCTC_MIN_30M = 11'h01e;
    localparam logic [10:0] CCTC_MIN_3H  = 11'h0b4;
    localparam logic [10:0] CCTC_MIN_9H  = 11'h21c;
    // current code landmarks (currents in units of 0.1 mA)
    localparam logic [6:0]  CCTC_LOW_LAST     = 7'h07;
    localparam logic [6:0]  CCTC_CHG_STEP10   = 7'h54;
    localparam logic [6:0]  CCTC_CHG_LAST     = 7'h6e;
    localparam logic [6:0]  CCTC_PRE_FINE_END = 7'h09;
    localparam logic [6:0]  CCTC_PRE_COARSE   = 7'h40;
    localparam logic [6:0]  CCTC_PRE_LAST     = 7'h6c;
    localparam logic [15:0] CCTC_LOW_BASE     = 16'h0014;
    localparam logic [15:0] CCTC_LOW_STEP     = 16'h0004;
    localparam logic [15:0] CCTC_CHG_BASE     = 16'h0032;
    localparam logic [15:0] CCTC_CHG_240      = 16'h0960;
    localparam logic [15:0] CCTC_STEP_1MA     = 16'h000a;
    localparam logic [15:0] CCTC_STEP_10MA    = 16'h0064;
    localparam logic [15:0] CCTC_PRE_STEP     = 16'h0005;
    localparam logic [15:0] CCTC_PRE_6MA      = 16'h003c;
endpackage

/* cctc_reg8.sv */
`timescale 1ns/1ps
// one configuration byte with write lock and reserved-bit mask
module cctc_reg8 #(
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] MSK = 8'hff
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       we,
    input  wire logic       lock,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q_ff
);
    logic [7:0] nxt_q; // next stored value

    // a locked write leaves the byte untouched
    always_comb begin
        nxt_q = q_ff;
        if (we && !lock) begin
            nxt_q = wdata & MSK;
        end
    end

    // storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= RST;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule // cctc_reg8

/* cctc_top_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the charger timer and current bank
module cctc_top_tb;
    logic        clk;                      // 50 MHz register clock
    logic        nrst;                     // async reset, active low
    logic        reg_wr;                   // write strobe
    logic        reg_rd;                   // read strobe
    logic [7:0]  reg_addr;                 // register offset
    logic [7:0]  reg_wdata;                // write data
    logic        charge_enable_n;          // 0 locks the timer byte
    logic        low_current_range_select; // low range for codes 0..7
    logic [7:0]  rdata;                    // read data seen
    logic        half;                     // half-rate flag
    logic        toff;                     // timer disabled flag
    logic [10:0] tmin;                     // effective period minutes
    logic [15:0] charge_current_code;                     // charge current, 0.1 mA
    logic        charge_current_code_res;                 // charge code reserved
    logic [15:0] ipre;                     // preterm current, 0.1 mA
    logic        ipre_res;                 // preterm code reserved
    int          err_total;                // mismatches
    int          n_tests;                  // comparisons

    cctc_top i_cctc_top (
        .clk                       (clk),
        .nrst                      (nrst),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .charge_enable_n           (charge_enable_n),
        .low_current_range_select  (low_current_range_select),
        .reg_rdata_ff              (rdata),
        .timer_half_rate_enable_ff (half),
        .timer_disabled_ff         (toff),
        .timer_period_min_ff       (tmin),
        .charge_current_dma_ff     (charge_current_code),
        .charge_code_reserved_ff   (charge_current_code_res),
        .preterm_current_dma_ff    (ipre),
        .preterm_code_reserved_ff  (ipre_res)
    );

    // free-running clock, 20 ns period
    always #10 clk = ~clk;

    // one compare for every kind of result; case inequality so x never matches
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run, also reached from the watchdog
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one-cycle write; returns once the decoded outputs have caught up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask

    // one-cycle read; data is held from the edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("read_data", {8'h00, exp}, {8'h00, rdata});
    endtask

    // timer byte write under a given lock level, then read back and decode
    task automatic tmr(input logic [7:0] d, input logic en_n, input logic [7:0] rb,
                       input logic [10:0] m, input logic h, input logic off);
        charge_enable_n = en_n;
        wr(8'h21, d);
        rd(8'h21, rb);
        chk("period_min", {5'h00, m}, {5'h00, tmin});
        chk("half_rate", {15'h0000, h}, {15'h0000, half});
        chk("timer_off", {15'h0000, off}, {15'h0000, toff});
    endtask

    // charge code write and decode check
    task automatic chg(input logic [7:0] c, input logic lo, input logic [15:0] e,
                       input logic r);
        low_current_range_select = lo;
        wr(8'h22, c);
        chk("charge_current", e, charge_current_code);
        chk("charge_reserved", {15'h0000, r}, {15'h0000, charge_current_code_res});
    endtask

    // precharge/termination code write and decode check
    task automatic pre(input logic [7:0] c, input logic [15:0] e, input logic r);
        wr(8'h23, c);
        chk("preterm_current", e, ipre);
        chk("preterm_reserved", {15'h0000, r}, {15'h0000, ipre_res});
    endtask

    // watchdog: the whole sequence is far shorter than this bound
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("[ERR] run_length expected end seen hang");
        complete_run();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        charge_enable_n = 1'b1;
        low_current_range_select = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (2) @(negedge clk);
        chk("half_in_reset", 16'h0001, {15'h0000, half});
        nrst = 1'b1;
        @(negedge clk);
        chk("period_min", 16'h0168, {5'h00, tmin});
        chk("charge_current", 16'h02bc, charge_current_code);
        chk("preterm_current", 16'h0019, ipre);
        rd(8'h21, 8'h19);
        rd(8'h22, 8'h41);
        rd(8'h23, 8'h04);
        tmr(8'h02, 1'b0, 8'h19, 11'h168, 1'b1, 1'b0);
        tmr(8'h02, 1'b1, 8'h02, 11'h21c, 1'b0, 1'b0);
        tmr(8'h00, 1'b1, 8'h00, 11'h01e, 1'b0, 1'b0);
        tmr(8'h03, 1'b1, 8'h03, 11'h000, 1'b0, 1'b1);
        tmr(8'h0a, 1'b1, 8'h0a, 11'h438, 1'b1, 1'b0);
        tmr(8'hff, 1'b1, 8'h7b, 11'h000, 1'b1, 1'b1);
        tmr(8'h01, 1'b0, 8'h7b, 11'h000, 1'b1, 1'b1);
        chg(8'h00, 1'b0, 16'h0032, 1'b0);
        chg(8'h53, 1'b0, 16'h0370, 1'b0);
        chg(8'h54, 1'b0, 16'h0960, 1'b0);
        chg(8'h6e, 1'b0, 16'h1388, 1'b0);
        chg(8'h6f, 1'b0, 16'h0000, 1'b1);
        chg(8'hff, 1'b0, 16'h0000, 1'b1);
        rd(8'h22, 8'h7f);
        chg(8'h00, 1'b1, 16'h0014, 1'b0);
        chg(8'h07, 1'b1, 16'h0030, 1'b0);
        chg(8'h08, 1'b1, 16'h0082, 1'b0);
        pre(8'h00, 16'h0005, 1'b0);
        pre(8'h09, 16'h0032, 1'b0);
        pre(8'h0a, 16'h0000, 1'b1);
        pre(8'h3f, 16'h0000, 1'b1);
        pre(8'h40, 16'h003c, 1'b0);
        pre(8'h6c, 16'h01f4, 1'b0);
        pre(8'h6d, 16'h0000, 1'b1);
        pre(8'h7f, 16'h0000, 1'b1);
        // unmapped offsets: writes vanish, reads give zero
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h21, 8'h7b);
        // second reset in mid-run restores the timer byte
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        rd(8'h21, 8'h19);
        chk("period_min", 16'h0168, {5'h00, tmin});
        complete_run();
    end
endmodule // cctc_top_tb
